// ---- hdl/sagen_map.svh ----
// Constants for the stack and address generation block
// How it works
// - Stack pointer holds next free word; stack grows upward.
// - Push writes at pointer then increments; pop decrements then reads.
// - Call push clears top bit of stored upper program counter word.
// - Exception push puts low status byte beside upper program counter bits.
// - Stack limit not reset; its bit zero always reads zero.
// - Addresses formed through stack pointer are compared with stack limit.
// - Push at limit does not trap; the next push does.
// - Stack pointer address below 0x0800 raises stack error.
// - File register direct field is 13 bits, first 8192 bytes; move reaches all.
// - File register ops use register zero; result to file or register zero.
// - First operand is register direct; second is register, memory or 5-bit literal.
// - Literal operands of 5 and 10 bits are supported.
// - Register indirect address is the unmodified pointer.
// - Post-modify uses pointer as address, then adds a signed constant.
// - Pre-modify adds signed constant first, modified value is address.
// - Indexed mode adds offset register; 4-bit field shared by both operands.
// - Literal offset mode adds instruction literal to pointer.
// - Move has independent source and destination modes, 8 and 16-bit literals.
// - Branch uses 16-bit signed literal; interrupt disable uses 14-bit unsigned.
// - Secure RAM segments reachable only from their own flash segment.
// - Program window is read-only and returns only the low word.
// - Table access reads and writes every byte, upper byte too.
`ifndef SAGEN_MAP_SVH
`define SAGEN_MAP_SVH
`define SAG_SP_IDX 4'hF
`define SAG_DEFAULT_WORK_REG_IDX 4'h0
`define SAG_SFR_TOP 16'h0800
`define SAG_NEAR_MASK 16'h1FFF
`define SAG_WIN_BIT 15
`define SAG_PUSH_STEP 16'h0002
`define SAG_BYTE_STEP 16'h0001
`define SAG_FILE_DEST 4'hF
`endif

// ---- hdl/sagen_pkg.sv ----
// Types for the stack and address generation block
package sagen_pkg;
  typedef enum logic [6:0] {
    SAG_FILE = 7'h01,
    SAG_DIRECT = 7'h02,
    SAG_IND = 7'h04,
    SAG_POST = 7'h08,
    SAG_PRE = 7'h10,
    SAG_INDEX = 7'h20,
    SAG_LITOFS = 7'h40
  } sag_mode_t;
  typedef enum logic [2:0] {
    SAG_LIT5 = 3'h1,
    SAG_LIT10 = 3'h2,
    SAG_LIT16 = 3'h4
  } sag_litw_t;
  typedef struct packed {
    sag_mode_t mode;
    logic [3:0] reg_idx;
    logic [15:0] lit;
    logic dec;
    logic byte_op;
  } sag_opd_t;
  typedef struct packed {
    logic [15:0] addr;
    logic valid;
    logic is_stack;
  } sag_ea_t;
endpackage

// ---- hdl/sagen_litext.sv ----
// Literal field extraction for the supported literal widths
`timescale 1ns/1ps
module sagen_litext (
  // Raw field and width select
  input wire logic [15:0] raw,
  input wire sagen_pkg::sag_litw_t width,
  input wire logic signed_lit,
  // Extended value
  output logic [15:0] value
);
  // Short literals widen by sign only when the decoder asks for it
  wire [15:0] lit5 = signed_lit ? {{11{raw[4]}}, raw[4:0]} : {11'h000, raw[4:0]};
  wire [15:0] lit10 = signed_lit ? {{6{raw[9]}}, raw[9:0]} : {6'h00, raw[9:0]};
  wire [15:0] lit16 = raw;
  assign value = (width == sagen_pkg::SAG_LIT5) ? lit5 :
                 (width == sagen_pkg::SAG_LIT10) ? lit10 : lit16;
endmodule

// ---- hdl/sagen_eacalc.sv ----
// Effective address computation for one operand
`timescale 1ns/1ps
`include "sagen_map.svh"
module sagen_eacalc (
  // Operand and register values
  input wire sagen_pkg::sag_opd_t opd,
  input wire logic [15:0] ptr_val,
  input wire logic [15:0] ofs_val,
  input wire logic is_move,
  // Results
  output logic [15:0] ea,
  output logic [15:0] ptr_new,
  output logic ptr_upd
);
  wire [15:0] step = opd.byte_op ? `SAG_BYTE_STEP : `SAG_PUSH_STEP;
  wire [15:0] moved = opd.dec ? ptr_val - step : ptr_val + step;
  wire [15:0] file_ea = is_move ? opd.lit : (opd.lit & `SAG_NEAR_MASK);
  always_comb begin
    ea = ptr_val;
    ptr_new = ptr_val;
    ptr_upd = 1'b0;
    case (opd.mode)
      sagen_pkg::SAG_FILE: ea = file_ea;
      sagen_pkg::SAG_DIRECT: ea = ptr_val;
      sagen_pkg::SAG_IND: ea = ptr_val;
      sagen_pkg::SAG_POST: begin
        ea = ptr_val;
        ptr_new = moved;
        ptr_upd = 1'b1;
      end
      sagen_pkg::SAG_PRE: begin
        ea = moved;
        ptr_new = moved;
        ptr_upd = 1'b1;
      end
      sagen_pkg::SAG_INDEX: ea = ptr_val + ofs_val;
      sagen_pkg::SAG_LITOFS: ea = ptr_val + opd.lit;
      default: ea = ptr_val;
    endcase
  end
endmodule

// ---- hdl/sagen_top.sv ----
// Stack and address generation core top
`timescale 1ns/1ps
`include "sagen_map.svh"
module sagen_top #(
  parameter int NREG = 16
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Instruction decoder request
  input wire logic REQ_VALID,
  input wire logic REQ_MOVE,
  input wire sagen_pkg::sag_opd_t SRC_OPD,
  input wire sagen_pkg::sag_opd_t DST_OPD,
  input wire logic [3:0] OFS_IDX,
  input wire logic [15:0] LIT_RAW,
  input wire sagen_pkg::sag_litw_t LIT_WIDTH,
  input wire logic LIT_SIGNED,
  input wire logic FILE_TO_DEFAULT_WORK_REG,
  // Stack operations
  input wire logic PUSH,
  input wire logic POP,
  input wire logic PUSH_CALL,
  input wire logic PUSH_EXC,
  input wire logic [15:0] PUSH_DATA,
  input wire logic [6:0] PC_UPPER,
  input wire logic [7:0] STATUS_LOW_BYTE,
  // Register writes
  input wire logic REG_WE,
  input wire logic [3:0] REG_WIDX,
  input wire logic [15:0] REG_WDATA,
  input wire logic LIMIT_WE,
  input wire logic [15:0] LIMIT_WDATA,
  // Security and program window
  input wire logic BOOT_RAM_EN,
  input wire logic SEC_RAM_EN,
  input wire logic [15:0] BOOT_RAM_LO,
  input wire logic [15:0] BOOT_RAM_HI,
  input wire logic [15:0] SEC_RAM_LO,
  input wire logic [15:0] SEC_RAM_HI,
  input wire logic CODE_IN_BOOT,
  input wire logic CODE_IN_SEC,
  input wire logic WINDOW_EN,
  input wire logic DST_WRITE,
  input wire logic TABLE_OP,
  input wire logic [23:0] PROG_WORD,
  input wire logic [1:0] TABLE_BYTE_SEL,
  // Results
  output sagen_pkg::sag_ea_t SRC_EA,
  output sagen_pkg::sag_ea_t DST_EA,
  output logic [15:0] STACK_ADDR,
  output logic [15:0] STACK_WDATA,
  output logic STACK_WE,
  output logic STACK_RE,
  output logic [15:0] LIT_VALUE,
  output logic [3:0] RESULT_IDX,
  output logic [15:0] WINDOW_DATA,
  output logic [7:0] TABLE_BYTE,
  output logic ACCESS_DENIED,
  output logic WINDOW_WRITE_ERR,
  output logic STACK_TRAP
);
  if (NREG != 16) begin : g_nreg_chk
    $error("Register file must hold 16 working registers");
  end

  logic [15:0] default_work_reg_r [NREG];
  logic [15:0] limit_r;
  logic [15:0] src_ea, dst_ea, src_new, dst_new, lit_val;
  logic src_upd, dst_upd;

  sagen_eacalc u_src (
    .opd(SRC_OPD),
    .ptr_val(default_work_reg_r[SRC_OPD.reg_idx]),
    .ofs_val(default_work_reg_r[OFS_IDX]),
    .is_move(REQ_MOVE),
    .ea(src_ea),
    .ptr_new(src_new),
    .ptr_upd(src_upd)
  );
  sagen_eacalc u_dst (
    .opd(DST_OPD),
    .ptr_val(default_work_reg_r[DST_OPD.reg_idx]),
    .ofs_val(default_work_reg_r[OFS_IDX]),
    .is_move(REQ_MOVE),
    .ea(dst_ea),
    .ptr_new(dst_new),
    .ptr_upd(dst_upd)
  );
  sagen_litext u_lit (
    .raw(LIT_RAW),
    .width(LIT_WIDTH),
    .signed_lit(LIT_SIGNED),
    .value(lit_val)
  );

  function automatic logic uses_sp(input sagen_pkg::sag_opd_t o);
    uses_sp = (o.reg_idx == `SAG_SP_IDX) && (o.mode != sagen_pkg::SAG_FILE) &&
              (o.mode != sagen_pkg::SAG_DIRECT);
  endfunction

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic denied(input logic [15:0] a, input logic bt, input logic sc,
                                  input logic [15:0] blo, input logic [15:0] bhi,
                                  input logic [15:0] slo, input logic [15:0] shi,
                                  input logic be, input logic se);
    denied = (be && in_range(a, blo, bhi) && !bt) || (se && in_range(a, slo, shi) && !sc);
  endfunction

  wire [15:0] sp = default_work_reg_r[`SAG_SP_IDX];
  wire [15:0] limit_rd = {limit_r[15:1], 1'b0};
  wire push_any = PUSH | PUSH_CALL | PUSH_EXC;
  wire [15:0] sp_after_push = sp + `SAG_PUSH_STEP;
  wire [15:0] sp_after_pop = sp - `SAG_PUSH_STEP;
  wire src_sp = REQ_VALID && uses_sp(SRC_OPD);
  wire dst_sp = REQ_VALID && uses_sp(DST_OPD);
  wire ovf_push = push_any && (sp > limit_rd);
  wire ovf_ea = (src_sp && (src_ea > limit_rd)) || (dst_sp && (dst_ea > limit_rd));
  wire unf_pop = POP && (sp_after_pop < `SAG_SFR_TOP);
  wire unf_ea = (src_sp && (src_ea < `SAG_SFR_TOP)) || (dst_sp && (dst_ea < `SAG_SFR_TOP));
  wire trap_nxt = ovf_push || ovf_ea || unf_pop || unf_ea;
  wire [15:0] call_word = {9'h000, PC_UPPER};
  wire [15:0] exc_word = {STATUS_LOW_BYTE, 1'b0, PC_UPPER};
  wire [15:0] push_word = PUSH_EXC ? exc_word : PUSH_CALL ? call_word : PUSH_DATA;
  wire [15:0] stack_addr_nxt = push_any ? sp : sp_after_pop;
  wire in_window = WINDOW_EN && dst_ea[`SAG_WIN_BIT] && REQ_VALID && !TABLE_OP;
  wire win_wr_err = in_window && DST_WRITE;
  wire deny_src = REQ_VALID && denied(src_ea, CODE_IN_BOOT, CODE_IN_SEC, BOOT_RAM_LO, BOOT_RAM_HI,
                                     SEC_RAM_LO, SEC_RAM_HI, BOOT_RAM_EN, SEC_RAM_EN);
  wire deny_dst = REQ_VALID && denied(dst_ea, CODE_IN_BOOT, CODE_IN_SEC, BOOT_RAM_LO, BOOT_RAM_HI,
                                     SEC_RAM_LO, SEC_RAM_HI, BOOT_RAM_EN, SEC_RAM_EN);
  wire [7:0] tbl_byte = (TABLE_BYTE_SEL == 2'h0) ? PROG_WORD[7:0] :
                        (TABLE_BYTE_SEL == 2'h1) ? PROG_WORD[15:8] : PROG_WORD[23:16];
  wire [3:0] result_idx_nxt = (DST_OPD.mode == sagen_pkg::SAG_FILE) ?
                              (FILE_TO_DEFAULT_WORK_REG ? `SAG_DEFAULT_WORK_REG_IDX : `SAG_FILE_DEST) : DST_OPD.reg_idx;

  // Limit has no reset on purpose; software must load it before the stack is trusted
  always_ff @(posedge SYS_CLK) begin
    if (LIMIT_WE) limit_r <= LIMIT_WDATA;
  end

  // Stack pointer and pointer updates; stack activity outranks operand updates
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NREG; i++) default_work_reg_r[i] <= 16'h0000;
      default_work_reg_r[`SAG_SP_IDX] <= `SAG_SFR_TOP;
    end else begin
      if (REG_WE) default_work_reg_r[REG_WIDX] <= REG_WDATA;
      if (REQ_VALID && src_upd) default_work_reg_r[SRC_OPD.reg_idx] <= src_new;
      if (REQ_VALID && dst_upd) default_work_reg_r[DST_OPD.reg_idx] <= dst_new;
      if (push_any) default_work_reg_r[`SAG_SP_IDX] <= sp_after_push;
      else if (POP) default_work_reg_r[`SAG_SP_IDX] <= sp_after_pop;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SRC_EA <= '0;
      DST_EA <= '0;
      STACK_ADDR <= 16'h0000;
      STACK_WDATA <= 16'h0000;
      STACK_WE <= 1'b0;
      STACK_RE <= 1'b0;
      LIT_VALUE <= 16'h0000;
      RESULT_IDX <= 4'h0;
      WINDOW_DATA <= 16'h0000;
      TABLE_BYTE <= 8'h00;
      ACCESS_DENIED <= 1'b0;
      WINDOW_WRITE_ERR <= 1'b0;
      STACK_TRAP <= 1'b0;
    end else begin
      SRC_EA <= '{addr: src_ea, valid: REQ_VALID, is_stack: src_sp};
      DST_EA <= '{addr: dst_ea, valid: REQ_VALID && !win_wr_err, is_stack: dst_sp};
      STACK_ADDR <= stack_addr_nxt;
      STACK_WDATA <= push_word;
      STACK_WE <= push_any;
      STACK_RE <= POP && !push_any;
      LIT_VALUE <= lit_val;
      RESULT_IDX <= result_idx_nxt;
      WINDOW_DATA <= PROG_WORD[15:0];
      TABLE_BYTE <= tbl_byte;
      ACCESS_DENIED <= deny_src || deny_dst;
      WINDOW_WRITE_ERR <= win_wr_err;
      STACK_TRAP <= trap_nxt;
    end
  end

  AST_PUSH_ADVANCE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (PUSH && !PUSH_CALL && !PUSH_EXC && !POP) |=> (sp == $past(sp) + `SAG_PUSH_STEP))
    else $error("Push did not advance stack pointer by one word");

  AST_POP_RETREAT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (POP && !PUSH && !PUSH_CALL && !PUSH_EXC) |=> (sp == $past(sp) - `SAG_PUSH_STEP && STACK_ADDR == sp))
    else $error("Pop did not read from decremented pointer");

  AST_PUSH_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    PUSH |=> (STACK_WE && STACK_ADDR == $past(sp)))
    else $error("Push not written at the free word");

  AST_PUSH_WE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    push_any |=> (STACK_WE && !STACK_RE))
    else $error("Push did not raise the write strobe alone");

  AST_POP_RE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (POP && !push_any) |=> (STACK_RE && !STACK_WE))
    else $error("Pop did not raise the read strobe alone");

  AST_CALL_MSB: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (PUSH_CALL && !PUSH_EXC) |=> !STACK_WDATA[15])
    else $error("Call push upper word top bit set");

  AST_CALL_WORD: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (PUSH_CALL && !PUSH_EXC) |=> (STACK_WDATA == 16'($past(PC_UPPER))))
    else $error("Call push word not zero extended");

  AST_EXC_SRL: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    PUSH_EXC |=> (STACK_WDATA[15:8] == $past(STATUS_LOW_BYTE)))
    else $error("Exception push lacks status byte");

  AST_EXC_LOW: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    PUSH_EXC |=> (STACK_WDATA[6:0] == $past(PC_UPPER) && !STACK_WDATA[7]))
    else $error("Exception push lost program counter bits");

  AST_AT_LIMIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (PUSH && !POP && sp == limit_rd && sp >= `SAG_SFR_TOP && !REQ_VALID) |=> !STACK_TRAP)
    else $error("Push at limit trapped");

  AST_OVER_LIMIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (PUSH && sp > limit_rd) |=> STACK_TRAP)
    else $error("Push beyond limit missed trap");

  AST_UNDERFLOW: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (POP && sp < (`SAG_SFR_TOP + `SAG_PUSH_STEP)) |=> STACK_TRAP)
    else $error("Underflow missed trap");

  AST_EA_STACK: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && SRC_OPD.reg_idx == `SAG_SP_IDX && SRC_OPD.mode == sagen_pkg::SAG_IND) |=> SRC_EA.is_stack)
    else $error("Stack pointer address not marked as stack");

  AST_EA_OVER: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (src_sp && src_ea > limit_rd) |=> STACK_TRAP)
    else $error("Stack address above limit missed trap");

  AST_EA_UNDER: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (dst_sp && dst_ea < `SAG_SFR_TOP) |=> STACK_TRAP)
    else $error("Stack address below special area missed trap");

  AST_QUIET: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (!push_any && !POP && !REQ_VALID) |=> !STACK_TRAP)
    else $error("Trap raised with no address generated");

  AST_FILE_NEAR: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && !REQ_MOVE && SRC_OPD.mode == sagen_pkg::SAG_FILE) |=>
    ((SRC_EA.addr & ~`SAG_NEAR_MASK) == 16'h0000))
    else $error("File address left the near area");

  AST_RESULT_DEFAULT_WORK_REG: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (DST_OPD.mode == sagen_pkg::SAG_FILE && FILE_TO_DEFAULT_WORK_REG) |=> (RESULT_IDX == `SAG_DEFAULT_WORK_REG_IDX))
    else $error("File result not sent to register zero");

  AST_LIT5_UNS: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (LIT_WIDTH == sagen_pkg::SAG_LIT5 && !LIT_SIGNED) |=> (LIT_VALUE[15:5] == 11'h000))
    else $error("Unsigned short literal not zero extended");

  AST_REQ_VALID: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    REQ_VALID |=> SRC_EA.valid)
    else $error("Source address not marked valid");

  AST_BOOT_DENY: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && BOOT_RAM_EN && !CODE_IN_BOOT && src_ea >= BOOT_RAM_LO && src_ea <= BOOT_RAM_HI) |=>
    ACCESS_DENIED)
    else $error("Boot secure segment reached from other code");

  AST_SEC_DENY: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && SEC_RAM_EN && !CODE_IN_SEC && dst_ea >= SEC_RAM_LO && dst_ea <= SEC_RAM_HI) |=>
    ACCESS_DENIED)
    else $error("Secure segment reached from other code");

  AST_NO_DENY: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !REQ_VALID |=> !ACCESS_DENIED)
    else $error("Access denied with no request");

  AST_WIN_LOW: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    1'b1 |=> (WINDOW_DATA == 16'($past(PROG_WORD))))
    else $error("Window returned other than low word");

  AST_WIN_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && WINDOW_EN && DST_WRITE && !TABLE_OP && dst_ea[`SAG_WIN_BIT]) |=>
    (WINDOW_WRITE_ERR && !DST_EA.valid))
    else $error("Window write not refused");

  AST_TABLE_OK: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    TABLE_OP |=> !WINDOW_WRITE_ERR)
    else $error("Table access refused as window write");

  AST_TABLE_UPPER: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (TABLE_BYTE_SEL == 2'h2) |=> ({TABLE_BYTE, 16'h0000} == ($past(PROG_WORD) & 24'hFF0000)))
    else $error("Table access missed the upper byte");

  AST_LIMIT_LSB: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    LIMIT_WE |=> (limit_rd[0] == 1'b0 && (limit_rd >> 1) == ($past(LIMIT_WDATA) >> 1)))
    else $error("Limit bit zero not forced clear");
endmodule

// ---- bench/sagen_mem_model.sv ----
// Data memory model on the stack side of the block
`timescale 1ns/1ps
module sagen_mem_model (
  // Clock
  input wire logic clk,
  // Stack port
  input wire logic we,
  input wire logic re,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  // Read data, one cycle after the read strobe
  output logic [15:0] rdata
);
  logic [15:0] mem [logic [15:0]];
  initial rdata = 16'h5A5A;
  always @(posedge clk) begin
    if (we) begin
      mem[addr] = wdata;
    end
    // No read, or a read of an unwritten word: the bus shows the inverse of its last value, so an old word comes back every second cycle
    if (re && mem.exists(addr)) begin
      rdata <= mem[addr];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule

// ---- bench/tb_stack_and_address_generation.sv ----
// Self-checking bench for the stack and address generation block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb_stack_and_address_generation;
  logic SYS_CLK = 1'b0, RSTN = 1'b0, REQ_VALID = 1'b0, REQ_MOVE = 1'b0, LIT_SIGNED = 1'b0, FILE_TO_DEFAULT_WORK_REG = 1'b0;
  logic PUSH = 1'b0, POP = 1'b0, PUSH_CALL = 1'b0, PUSH_EXC = 1'b0, REG_WE = 1'b0, LIMIT_WE = 1'b0;
  logic BOOT_RAM_EN = 1'b0, SEC_RAM_EN = 1'b0, CODE_IN_BOOT = 1'b0, CODE_IN_SEC = 1'b0;
  logic WINDOW_EN = 1'b0, DST_WRITE = 1'b0, TABLE_OP = 1'b0;
  logic [3:0] OFS_IDX = 4'h0, REG_WIDX = 4'h0;
  logic [15:0] LIT_RAW = 16'h0000, PUSH_DATA = 16'h0000, REG_WDATA = 16'h0000, LIMIT_WDATA = 16'h0000;
  logic [15:0] BOOT_RAM_LO = 16'h1000, BOOT_RAM_HI = 16'h10FF, SEC_RAM_LO = 16'h1100, SEC_RAM_HI = 16'h11FF;
  logic [6:0] PC_UPPER = 7'h00;
  logic [7:0] STATUS_LOW_BYTE = 8'h00;
  logic [23:0] PROG_WORD = 24'h000000;
  logic [1:0] TABLE_BYTE_SEL = 2'h0;
  sagen_pkg::sag_opd_t SRC_OPD = '0, DST_OPD = '0;
  sagen_pkg::sag_litw_t LIT_WIDTH = sagen_pkg::SAG_LIT5;
  sagen_pkg::sag_ea_t SRC_EA, DST_EA;
  logic [15:0] STACK_ADDR, STACK_WDATA, LIT_VALUE, WINDOW_DATA, mem_rdata;
  logic STACK_WE, STACK_RE, ACCESS_DENIED, WINDOW_WRITE_ERR, STACK_TRAP;
  logic [3:0] RESULT_IDX;
  logic [7:0] TABLE_BYTE;
  int n_mismatch = 0;
  int tests_run = 0;
  sagen_top dut_u (.SYS_CLK, .RSTN, .REQ_VALID, .REQ_MOVE, .SRC_OPD, .DST_OPD, .OFS_IDX, .LIT_RAW, .LIT_WIDTH,
    .LIT_SIGNED, .FILE_TO_DEFAULT_WORK_REG, .PUSH, .POP, .PUSH_CALL, .PUSH_EXC, .PUSH_DATA, .PC_UPPER, .STATUS_LOW_BYTE,
    .REG_WE, .REG_WIDX, .REG_WDATA, .LIMIT_WE, .LIMIT_WDATA, .BOOT_RAM_EN, .SEC_RAM_EN, .BOOT_RAM_LO,
    .BOOT_RAM_HI, .SEC_RAM_LO, .SEC_RAM_HI, .CODE_IN_BOOT, .CODE_IN_SEC, .WINDOW_EN, .DST_WRITE, .TABLE_OP,
    .PROG_WORD, .TABLE_BYTE_SEL, .SRC_EA, .DST_EA, .STACK_ADDR, .STACK_WDATA, .STACK_WE, .STACK_RE, .LIT_VALUE,
    .RESULT_IDX, .WINDOW_DATA, .TABLE_BYTE, .ACCESS_DENIED, .WINDOW_WRITE_ERR, .STACK_TRAP);
  sagen_mem_model mem_u (.clk(SYS_CLK), .we(STACK_WE), .re(STACK_RE), .addr(STACK_ADDR), .wdata(STACK_WDATA),
    .rdata(mem_rdata));
  always #12.5 SYS_CLK = ~SYS_CLK;
  task automatic fire;
    @(posedge SYS_CLK);
    {REQ_VALID, PUSH, POP, PUSH_CALL, PUSH_EXC, REG_WE, LIMIT_WE} <= '0;
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] i, input logic [15:0] d);
    @(posedge SYS_CLK);
    REG_WE <= 1'b1;
    REG_WIDX <= i;
    REG_WDATA <= d;
    fire();
  endtask
  task automatic lim_wr(input logic [15:0] d);
    @(posedge SYS_CLK);
    LIMIT_WE <= 1'b1;
    LIMIT_WDATA <= d;
    fire();
    // A spare cycle keeps any pointer read away from the limit write
    @(posedge SYS_CLK);
  endtask
  task automatic push_chk(input logic [1:0] k, input logic [15:0] d, input logic [15:0] a, input logic t);
    @(posedge SYS_CLK);
    PUSH <= (k == 2'h0);
    {PUSH_EXC, PUSH_CALL} <= k;
    PUSH_DATA <= d;
    fire();
    `CHK(STACK_WE, 1'b1)
    `CHK(STACK_ADDR, a)
    `CHK(STACK_TRAP, t)
  endtask
  task automatic pop_chk(input logic [15:0] a, input logic [15:0] d, input logic t);
    @(posedge SYS_CLK);
    POP <= 1'b1;
    fire();
    `CHK(STACK_RE, 1'b1)
    `CHK(STACK_ADDR, a)
    `CHK(STACK_TRAP, t)
    @(posedge SYS_CLK);
    #1;
    if (!t) `CHK(mem_rdata, d)
  endtask
  task automatic ea_chk(input sagen_pkg::sag_mode_t m, input logic [3:0] i, input logic [15:0] l,
    input logic dc, input logic mv, input logic [15:0] e);
    @(posedge SYS_CLK);
    SRC_OPD <= '{m, i, l, dc, 1'b0};
    REQ_VALID <= 1'b1;
    REQ_MOVE <= mv;
    fire();
    `CHK(SRC_EA.addr, e)
  endtask
  task automatic t_stack;
    lim_wr(16'h0801);
    push_chk(2'h0, 16'h1111, 16'h0800, 1'b0);
    push_chk(2'h0, 16'h2222, 16'h0802, 1'b1);
    ea_chk(sagen_pkg::SAG_IND, 4'hF, 16'h0000, 1'b0, 1'b0, 16'h0804);
    `CHK(STACK_TRAP, 1'b1)
    `CHK(SRC_EA.is_stack, 1'b1)
    `CHK(SRC_EA.valid, 1'b1)
    `CHK(DST_EA.is_stack, 1'b0)
    reg_wr(4'hF, 16'h0804);
    pop_chk(16'h0802, 16'h2222, 1'b0);
    pop_chk(16'h0800, 16'h1111, 1'b0);
    pop_chk(16'h07FE, 16'h0000, 1'b1);
    $display("test stack done");
  endtask
  task automatic t_pcwords;
    lim_wr(16'h0A00);
    reg_wr(4'hF, 16'h0900);
    PC_UPPER <= 7'h7F;
    STATUS_LOW_BYTE <= 8'hA5;
    push_chk(2'h1, 16'hFFFF, 16'h0900, 1'b0);
    `CHK(STACK_WDATA, 16'h007F)
    push_chk(2'h2, 16'hFFFF, 16'h0902, 1'b0);
    `CHK(STACK_WDATA, 16'hA57F)
    $display("test pc words done");
  endtask
  task automatic t_modes;
    reg_wr(4'h3, 16'h1234);
    reg_wr(4'h4, 16'h0010);
    OFS_IDX <= 4'h4;
    DST_OPD <= '{sagen_pkg::SAG_IND, 4'h4, 16'h0000, 1'b0, 1'b0};
    ea_chk(sagen_pkg::SAG_IND, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h1234);
    ea_chk(sagen_pkg::SAG_POST, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h1234);
    ea_chk(sagen_pkg::SAG_IND, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h1236);
    ea_chk(sagen_pkg::SAG_PRE, 4'h3, 16'h0000, 1'b1, 1'b0, 16'h1234);
    ea_chk(sagen_pkg::SAG_INDEX, 4'h3, 16'h0000, 1'b0, 1'b1, 16'h1244);
    `CHK(DST_EA.addr, 16'h0010)
    ea_chk(sagen_pkg::SAG_LITOFS, 4'h3, 16'h0008, 1'b0, 1'b0, 16'h123C);
    ea_chk(sagen_pkg::SAG_FILE, 4'h0, 16'hFFFF, 1'b0, 1'b0, 16'h1FFF);
    DST_OPD <= '{sagen_pkg::SAG_FILE, 4'h0, 16'h0100, 1'b0, 1'b0};
    FILE_TO_DEFAULT_WORK_REG <= 1'b1;
    ea_chk(sagen_pkg::SAG_FILE, 4'h0, 16'hFFFF, 1'b0, 1'b1, 16'hFFFF);
    `CHK(RESULT_IDX, 4'h0)
    FILE_TO_DEFAULT_WORK_REG <= 1'b0;
    ea_chk(sagen_pkg::SAG_FILE, 4'h0, 16'h0100, 1'b0, 1'b0, 16'h0100);
    `CHK(RESULT_IDX, 4'hF)
    $display("test modes done");
  endtask
  task automatic lit_chk(input logic [15:0] r, input sagen_pkg::sag_litw_t w, input logic s, input logic [15:0] e);
    @(posedge SYS_CLK);
    LIT_RAW <= r;
    LIT_WIDTH <= w;
    LIT_SIGNED <= s;
    REQ_VALID <= 1'b1;
    fire();
    `CHK(LIT_VALUE, e)
  endtask
  task automatic t_lits;
    lit_chk(16'hFFFF, sagen_pkg::SAG_LIT5, 1'b0, 16'h001F);
    lit_chk(16'hFFFF, sagen_pkg::SAG_LIT10, 1'b0, 16'h03FF);
    lit_chk(16'h0010, sagen_pkg::SAG_LIT5, 1'b1, 16'hFFF0);
    lit_chk(16'h0200, sagen_pkg::SAG_LIT10, 1'b1, 16'hFE00);
    lit_chk(16'h8001, sagen_pkg::SAG_LIT16, 1'b1, 16'h8001);
    lit_chk(16'h3FFF, sagen_pkg::SAG_LIT16, 1'b0, 16'h3FFF);
    $display("test literals done");
  endtask
  task automatic t_window;
    WINDOW_EN <= 1'b1;
    PROG_WORD <= 24'hABCDEF;
    DST_OPD <= '{sagen_pkg::SAG_FILE, 4'h0, 16'h8000, 1'b0, 1'b0};
    ea_chk(sagen_pkg::SAG_IND, 4'h3, 16'h0000, 1'b0, 1'b1, 16'h1234);
    `CHK(WINDOW_DATA, 16'hCDEF)
    `CHK(WINDOW_WRITE_ERR, 1'b0)
    DST_WRITE <= 1'b1;
    ea_chk(sagen_pkg::SAG_IND, 4'h3, 16'h0000, 1'b0, 1'b1, 16'h1234);
    `CHK(WINDOW_WRITE_ERR, 1'b1)
    `CHK(DST_EA.valid, 1'b0)
    // Window and write stay up: a table access must still be let through
    TABLE_OP <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      TABLE_BYTE_SEL <= 2'(i);
      ea_chk(sagen_pkg::SAG_IND, 4'h3, 16'h0000, 1'b0, 1'b1, 16'h1234);
      `CHK(TABLE_BYTE, 8'(24'hABCDEF >> (8 * i)))
      `CHK(WINDOW_WRITE_ERR, 1'b0)
    end
    {WINDOW_EN, DST_WRITE, TABLE_OP} <= 3'b000;
    $display("test window done");
  endtask
  task automatic t_secure;
    {BOOT_RAM_EN, SEC_RAM_EN} <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      CODE_IN_BOOT <= !i[1] && i[0];
      CODE_IN_SEC <= i[1] && i[0];
      ea_chk(sagen_pkg::SAG_FILE, 4'h0, i[1] ? 16'h1110 : 16'h1010, 1'b0, 1'b1, i[1] ? 16'h1110 : 16'h1010);
      `CHK(ACCESS_DENIED, !i[0])
    end
    $display("test secure done");
  endtask
  task automatic t_reset;
    @(posedge SYS_CLK);
    RSTN <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    `CHK(STACK_WE, 1'b0)
    `CHK(STACK_TRAP, 1'b0)
    @(posedge SYS_CLK);
    RSTN <= 1'b1;
    // Limit survives reset, so a push at the reset pointer stays below it
    push_chk(2'h0, 16'h3333, 16'h0800, 1'b0);
    $display("test reset done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    t_stack();
    t_pcwords();
    t_modes();
    t_lits();
    t_window();
    t_secure();
    t_reset();
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge SYS_CLK);
    n_mismatch++;
    $display("Error %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
